// ### iscp_pkg.sv
// Constants, types and helpers for the two-wire slave command engine.
// Assumes a byte-wide memory behind the engine, addressed per page.
package iscp_pkg;

   // Bus address: upper nibble fixed, next two bits from the strap
   localparam logic [3:0] SLV_ADDR_HI = 4'ha;

   // Command codes
   localparam logic [7:0] CMD_BLK_WR = 8'h94;
   localparam logic [7:0] CMD_BLK_RD = 8'h95;
   localparam logic [7:0] CMD_REBOOT = 8'h96;
   localparam logic [7:0] CMD_FAULT = 8'h97;
   localparam logic [7:0] CMD_EXT_ON = 8'h98;
   localparam logic [7:0] CMD_EXT_OFF = 8'h99;
   localparam logic [7:0] CMD_EE_ON = 8'h9a;
   localparam logic [7:0] CMD_EE_OFF = 8'h9b;

   // Page selection codes on the memory port
   localparam logic [1:0] PAGE_DEF = 2'h0;
   localparam logic [1:0] PAGE_EXT = 2'h1;
   localparam logic [1:0] PAGE_EE = 2'h2;

   // Address limits
   localparam logic [7:0] CFG_LAST = 8'h7d;
   localparam logic [7:0] EXT_LAST = 8'hff;
   localparam logic [7:0] EE_LAST = 8'hff;
   localparam logic [7:0] BOOT_FIRST = 8'h0f;
   localparam logic [7:0] BOOT_LAST = 8'h7d;
   localparam logic [7:0] PTR_RST = 8'h00;

   // Block transfer sizes
   localparam logic [4:0] BLK_MAX = 5'h10;
   localparam logic [7:0] BLK_RD_COUNT = 8'h10;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Requests passed from the link side to the system side
   typedef enum logic [1:0] {OP_RD, OP_WR, OP_REBOOT, OP_FAULT} iscp_op_e;

   // Link-side protocol states
   typedef enum logic [2:0] {LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_WR_BYTE,
      LS_WR_ACK, LS_RD_BYTE, LS_RD_ACK, LS_IGNORE} iscp_lstate_e;

   // What further write bytes of a transaction mean
   typedef enum logic [1:0] {WK_NONE, WK_PTR, WK_BLK} iscp_kind_e;

   // System-side memory sequencer states
   typedef enum logic [2:0] {SS_IDLE, SS_RD_WAIT, SS_RD_TAKE, SS_CP_RD,
      SS_CP_WAIT, SS_CP_WR} iscp_sstate_e;

   // Address legal on the selected page
   function automatic logic addr_valid(input logic [1:0] page,
                                       input logic [7:0] a);
      begin
         if (page == PAGE_EE)
            addr_valid = (a <= EE_LAST);
         else if (page == PAGE_EXT)
            addr_valid = (a <= EXT_LAST);
         else
            addr_valid = (a <= CFG_LAST);
      end
   endfunction

   // Increment that sticks at a limit
   function automatic logic [7:0] sat_inc(input logic [7:0] a,
                                          input logic [7:0] lim);
      begin
         if (a >= lim)
            sat_inc = lim;
         else
            sat_inc = a + 8'h01;
      end
   endfunction

endpackage

// ### iscp_slave.sv
// Two-wire slave command engine: link side on clk_link_i, memory side on
// clk_sys_i. Assumes memory read data valid one cycle after a read strobe.
//
// Summary of operation
// - Accepted memory address byte loads the internal address pointer.
// - Disallowed address or command byte after slave address gets NACK.
// - Codes 94h and 95h are acknowledged as single sent bytes.
// - STOP before the address-byte acknowledge leaves pointer unchanged.
// - Command 96h reboots; copies EEPROM 0Fh..7Dh into default page.
// - Receive byte returns byte at pointer, then pointer advances one.
// - Write byte stores data only at a valid, acknowledged address.
// - Single byte accesses target the currently selected page.
// - Read byte: address, repeated start, one byte; bad address NACKed.
// - Command 97h requests a fault store to nonvolatile memory.
// - Command 98h selects extended page, 99h returns to default page.
// - Command 9Ah selects EEPROM page until 9Bh restores default.
// - Block write: 94h, count 1..16, n data bytes, all acknowledged.
// - Block write starts at pointer, leaves pointer at next address.
// - Block write pointer sticks at FFh in EEPROM, 7Dh otherwise.
// - Block command NACKed when busy; pointer then unaltered.
// - Block read returns count 16, then data bytes from pointer.
// - Master NACK or early STOP ends block read data.
// - Block read pointer sticks at FFh, repeating that byte.
// - Bus address is 1010 plus two strap bits; lowest bit ignored.
// - NACK after reboot, during nonvolatile write, or on bad address.
// - Repeated start acts as start; STOP ignored in START's high pulse.
`timescale 1ns/1ps
`default_nettype none

module iscp_slave
   import iscp_pkg::*;
(
   // System clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Link sampling clock
   input wire logic clk_link_i,
   // Two-wire pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [1:0] addr_strap_input_i,
   // Memory port
   output logic mem_en_o,
   output logic mem_we_o,
   output logic [1:0] mem_page_o,
   output logic [7:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i,
   // Device control
   input wire logic nv_busy_i,
   output logic reboot_o,
   output logic boot_busy_o,
   output logic fault_store_o
);

   // Link-side registers
   logic rst_lk_meta_r, rst_lk_r;
   logic scl_meta_r, scl_r, scl_d_r;
   logic sda_meta_r, sda_r, sda_d_r;
   logic [1:0] strap_meta_r, strap_r;
   logic busy_meta_r, busy_lk_r;
   logic ack_meta_r, ack_lk_r, ack_prev_r;
   logic start_hi_r;
   iscp_lstate_e state_r;
   iscp_kind_e kind_r;
   logic [3:0] bitcnt_r;
   logic [7:0] sh_r;
   logic sda_oe_r;
   logic is_read_r, first_r, blk_rd_r, data_byte_r, mack_r;
   logic [4:0] blk_n_r, blk_cnt_r, rd_cnt_r;
   logic [1:0] page_r;
   logic [7:0] ptr_r, fetch_r, rdbuf_r;
   logic req_tgl_r;
   iscp_op_e req_op_r;
   logic [7:0] req_addr_r, req_data_r;
   logic [1:0] req_page_r;

   // System-side registers
   logic req_meta_r, req_s_r, req_d_r;
   logic ack_tgl_r, busy_r;
   iscp_sstate_e sstate_r;
   logic [7:0] cp_addr_r, rd_hold_r;

   // Bus events seen by the link side
   logic scl_rise, scl_fall, start_ev, stop_ev, addr_match;
   logic [7:0] wr_lim;

   assign scl_rise = scl_r & ~scl_d_r;
   assign scl_fall = ~scl_r & scl_d_r;
   assign start_ev = scl_r & scl_d_r & sda_d_r & ~sda_r;
   assign stop_ev = scl_r & scl_d_r & ~sda_d_r & sda_r;
   assign addr_match = (sh_r[7:4] == SLV_ADDR_HI) &&
                       (sh_r[3:2] == strap_r);
   assign wr_lim = (page_r == PAGE_EE) ? EE_LAST : CFG_LAST;

   // Open-drain data pin only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_o = sda_oe_r;

   // Reset, pin, strap, busy and answer synchronisers
   always_ff @(posedge clk_link_i)
   begin
      rst_lk_meta_r <= sys_rst_i;
      rst_lk_r <= rst_lk_meta_r;
      scl_meta_r <= scl_i;
      scl_r <= scl_meta_r;
      scl_d_r <= scl_r;
      sda_meta_r <= sda_i;
      sda_r <= sda_meta_r;
      sda_d_r <= sda_r;
      strap_meta_r <= addr_strap_input_i;
      strap_r <= strap_meta_r;
      busy_meta_r <= busy_r;
      busy_lk_r <= busy_meta_r;
      ack_meta_r <= ack_tgl_r;
      ack_lk_r <= ack_meta_r;
   end

   // Catch read data when the system side answers
   always_ff @(posedge clk_link_i)
   begin
      if (rst_lk_r)
      begin
         ack_prev_r <= 1'b0;
         rdbuf_r <= 8'h00;
      end
      else
      begin
         ack_prev_r <= ack_lk_r;
         if (ack_lk_r != ack_prev_r)
            rdbuf_r <= rd_hold_r;
      end
   end

   // Marks the clock-high pulse that carried a START
   always_ff @(posedge clk_link_i)
   begin
      if (rst_lk_r)
         start_hi_r <= 1'b0;
      else if (start_ev)
         start_hi_r <= 1'b1;
      else if (scl_fall)
         start_hi_r <= 1'b0;
   end

   // Link protocol engine
   always_ff @(posedge clk_link_i)
   begin
      if (rst_lk_r)
      begin
         state_r <= LS_IDLE;
         kind_r <= WK_NONE;
         bitcnt_r <= 4'h0;
         sh_r <= 8'h00;
         sda_oe_r <= 1'b0;
         is_read_r <= 1'b0;
         first_r <= 1'b0;
         blk_rd_r <= 1'b0;
         data_byte_r <= 1'b0;
         mack_r <= 1'b0;
         blk_n_r <= 5'h00;
         blk_cnt_r <= 5'h00;
         rd_cnt_r <= 5'h00;
         page_r <= PAGE_DEF;
         ptr_r <= PTR_RST;
         fetch_r <= PTR_RST;
         req_tgl_r <= 1'b0;
         req_op_r <= OP_RD;
         req_addr_r <= 8'h00;
         req_data_r <= 8'h00;
         req_page_r <= PAGE_DEF;
      end
      else if (start_ev)
      begin
         state_r <= LS_ADDR;
         bitcnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
         kind_r <= WK_NONE;
         first_r <= 1'b1;
      end
      else if (stop_ev && !start_hi_r)
      begin
         state_r <= LS_IDLE;
         sda_oe_r <= 1'b0;
         blk_rd_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            LS_ADDR, LS_WR_BYTE:
            begin
               if (scl_rise)
               begin
                  sh_r <= {sh_r[6:0], sda_r};
                  bitcnt_r <= bitcnt_r + 4'h1;
               end
               else if (scl_fall && bitcnt_r == BITS_PER_BYTE)
               begin
                  bitcnt_r <= 4'h0;
                  if (state_r == LS_ADDR)
                  begin
                     if (!addr_match)
                        state_r <= LS_IGNORE;
                     else
                     begin
                        sda_oe_r <= 1'b1;
                        state_r <= LS_ADDR_ACK;
                        is_read_r <= sh_r[0];
                        if (sh_r[0])
                        begin
                           // Prefetch the byte at the pointer
                           fetch_r <= ptr_r;
                           req_op_r <= OP_RD;
                           req_addr_r <= ptr_r;
                           req_page_r <= page_r;
                           req_tgl_r <= ~req_tgl_r;
                        end
                        else
                           blk_rd_r <= 1'b0;
                     end
                  end
                  else if (first_r)
                  begin
                     first_r <= 1'b0;
                     if (busy_lk_r)
                        state_r <= LS_IGNORE;
                     else
                     begin
                        sda_oe_r <= 1'b1;
                        state_r <= LS_WR_ACK;
                        case (sh_r)
                           CMD_BLK_WR:
                           begin
                              kind_r <= WK_BLK;
                              blk_n_r <= 5'h00;
                              blk_cnt_r <= 5'h00;
                           end
                           CMD_BLK_RD:
                              blk_rd_r <= 1'b1;
                           CMD_REBOOT:
                           begin
                              page_r <= PAGE_DEF;
                              ptr_r <= PTR_RST;
                              req_op_r <= OP_REBOOT;
                              req_tgl_r <= ~req_tgl_r;
                           end
                           CMD_FAULT:
                           begin
                              req_op_r <= OP_FAULT;
                              req_tgl_r <= ~req_tgl_r;
                           end
                           CMD_EXT_ON:
                              page_r <= PAGE_EXT;
                           CMD_EXT_OFF:
                              page_r <= PAGE_DEF;
                           CMD_EE_ON:
                              page_r <= PAGE_EE;
                           CMD_EE_OFF:
                              page_r <= PAGE_DEF;
                           default:
                           begin
                              if (addr_valid(page_r, sh_r))
                              begin
                                 ptr_r <= sh_r;
                                 kind_r <= WK_PTR;
                              end
                              else
                              begin
                                 sda_oe_r <= 1'b0;
                                 state_r <= LS_IGNORE;
                              end
                           end
                        endcase
                     end
                  end
                  else if (busy_lk_r || kind_r == WK_NONE)
                     state_r <= LS_IGNORE;
                  else if (kind_r == WK_PTR)
                  begin
                     sda_oe_r <= 1'b1;
                     state_r <= LS_WR_ACK;
                     kind_r <= WK_NONE;
                     req_op_r <= OP_WR;
                     req_addr_r <= ptr_r;
                     req_data_r <= sh_r;
                     req_page_r <= page_r;
                     req_tgl_r <= ~req_tgl_r;
                  end
                  else if (blk_n_r == 5'h00)
                  begin
                     if (sh_r != 8'h00 && sh_r <= {3'h0, BLK_MAX})
                     begin
                        sda_oe_r <= 1'b1;
                        state_r <= LS_WR_ACK;
                        blk_n_r <= sh_r[4:0];
                     end
                     else
                        state_r <= LS_IGNORE;
                  end
                  else if (blk_cnt_r < blk_n_r)
                  begin
                     sda_oe_r <= 1'b1;
                     state_r <= LS_WR_ACK;
                     blk_cnt_r <= blk_cnt_r + 5'h01;
                     ptr_r <= sat_inc(ptr_r, wr_lim);
                     req_op_r <= OP_WR;
                     req_addr_r <= ptr_r;
                     req_data_r <= sh_r;
                     req_page_r <= page_r;
                     req_tgl_r <= ~req_tgl_r;
                  end
                  else
                     state_r <= LS_IGNORE;
               end
            end
            LS_ADDR_ACK, LS_WR_ACK:
            begin
               if (scl_fall)
               begin
                  if (state_r == LS_ADDR_ACK && is_read_r)
                  begin
                     state_r <= LS_RD_BYTE;
                     if (blk_rd_r)
                     begin
                        sh_r <= BLK_RD_COUNT;
                        sda_oe_r <= ~BLK_RD_COUNT[7];
                        data_byte_r <= 1'b0;
                        rd_cnt_r <= 5'h00;
                     end
                     else
                     begin
                        sh_r <= rdbuf_r;
                        sda_oe_r <= ~rdbuf_r[7];
                        data_byte_r <= 1'b1;
                        rd_cnt_r <= BLK_MAX;
                     end
                  end
                  else
                  begin
                     sda_oe_r <= 1'b0;
                     state_r <= LS_WR_BYTE;
                  end
               end
            end
            LS_RD_BYTE:
            begin
               if (scl_rise)
                  bitcnt_r <= bitcnt_r + 4'h1;
               else if (scl_fall)
               begin
                  if (bitcnt_r == BITS_PER_BYTE)
                  begin
                     sda_oe_r <= 1'b0;
                     state_r <= LS_RD_ACK;
                  end
                  else
                  begin
                     sh_r <= {sh_r[6:0], 1'b0};
                     sda_oe_r <= ~sh_r[6];
                  end
               end
            end
            LS_RD_ACK:
            begin
               if (scl_rise)
               begin
                  mack_r <= ~sda_r;
                  bitcnt_r <= 4'h0;
                  if (data_byte_r)
                     ptr_r <= sat_inc(ptr_r, EE_LAST);
               end
               else if (scl_fall)
               begin
                  if (mack_r && blk_rd_r && rd_cnt_r < BLK_MAX)
                  begin
                     state_r <= LS_RD_BYTE;
                     sh_r <= rdbuf_r;
                     sda_oe_r <= ~rdbuf_r[7];
                     data_byte_r <= 1'b1;
                     rd_cnt_r <= rd_cnt_r + 5'h01;
                     fetch_r <= sat_inc(fetch_r, EE_LAST);
                     req_op_r <= OP_RD;
                     req_addr_r <= sat_inc(fetch_r, EE_LAST);
                     req_page_r <= page_r;
                     req_tgl_r <= ~req_tgl_r;
                  end
                  else
                     state_r <= LS_IGNORE;
               end
            end
            default:
               sda_oe_r <= 1'b0;
         endcase
      end
   end

   // Request toggle synchroniser on the system side
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         req_meta_r <= 1'b0;
         req_s_r <= 1'b0;
         req_d_r <= 1'b0;
      end
      else
      begin
         req_meta_r <= req_tgl_r;
         req_s_r <= req_meta_r;
         req_d_r <= req_s_r;
      end
   end

   // Busy level seen by the link side
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         busy_r <= 1'b1;
      else
         busy_r <= nv_busy_i || sstate_r == SS_CP_RD ||
                   sstate_r == SS_CP_WAIT || sstate_r == SS_CP_WR;
   end

   assign boot_busy_o = busy_r;

   // Memory sequencer: link requests and boot copy
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         sstate_r <= SS_CP_RD;
         cp_addr_r <= BOOT_FIRST;
         ack_tgl_r <= 1'b0;
         rd_hold_r <= 8'h00;
         mem_en_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_page_o <= PAGE_DEF;
         mem_addr_o <= 8'h00;
         mem_wdata_o <= 8'h00;
         reboot_o <= 1'b0;
         fault_store_o <= 1'b0;
      end
      else
      begin
         mem_en_o <= 1'b0;
         mem_we_o <= 1'b0;
         reboot_o <= 1'b0;
         fault_store_o <= 1'b0;
         case (sstate_r)
            SS_IDLE:
            begin
               if (req_s_r != req_d_r)
               begin
                  case (req_op_r)
                     OP_RD:
                     begin
                        mem_en_o <= 1'b1;
                        mem_page_o <= req_page_r;
                        mem_addr_o <= req_addr_r;
                        sstate_r <= SS_RD_WAIT;
                     end
                     OP_WR:
                     begin
                        mem_en_o <= 1'b1;
                        mem_we_o <= 1'b1;
                        mem_page_o <= req_page_r;
                        mem_addr_o <= req_addr_r;
                        mem_wdata_o <= req_data_r;
                        ack_tgl_r <= ~ack_tgl_r;
                     end
                     OP_REBOOT:
                     begin
                        reboot_o <= 1'b1;
                        cp_addr_r <= BOOT_FIRST;
                        sstate_r <= SS_CP_RD;
                        ack_tgl_r <= ~ack_tgl_r;
                     end
                     default:
                     begin
                        fault_store_o <= 1'b1;
                        ack_tgl_r <= ~ack_tgl_r;
                     end
                  endcase
               end
            end
            SS_RD_WAIT:
               sstate_r <= SS_RD_TAKE;
            SS_RD_TAKE:
            begin
               rd_hold_r <= mem_rdata_i;
               ack_tgl_r <= ~ack_tgl_r;
               sstate_r <= SS_IDLE;
            end
            SS_CP_RD:
            begin
               mem_en_o <= 1'b1;
               mem_page_o <= PAGE_EE;
               mem_addr_o <= cp_addr_r;
               sstate_r <= SS_CP_WAIT;
            end
            SS_CP_WAIT:
               sstate_r <= mem_we_o ? SS_CP_RD : SS_CP_WR; // Strobe gap
            SS_CP_WR:
            begin
               mem_en_o <= 1'b1;
               mem_we_o <= 1'b1;
               mem_page_o <= PAGE_DEF;
               mem_addr_o <= cp_addr_r;
               mem_wdata_o <= mem_rdata_i;
               cp_addr_r <= cp_addr_r + 8'h01;
               if (cp_addr_r == BOOT_LAST)
                  sstate_r <= SS_IDLE;
               else
                  sstate_r <= SS_CP_WAIT;
            end
            default:
               sstate_r <= SS_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

// ### iscp_slave_properties.sv
// Checker of the slave engine's memory and control ports.
// Assumes it is bound to every slave engine instance.
`timescale 1ns/1ps
`default_nettype none
module iscp_slave_properties
   import iscp_pkg::*;
(
   // Clock, reset and inputs
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic nv_busy_i,
   // Watched outputs
   input wire logic mem_en_o,
   input wire logic mem_we_o,
   input wire logic [1:0] mem_page_o,
   input wire logic [7:0] mem_addr_o,
   input wire logic reboot_o,
   input wire logic boot_busy_o,
   input wire logic fault_store_o
);
   // All checks on the system clock
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   // Strobe and pulse relations
   chk_strobe_gap: assert property (mem_en_o |=> !mem_en_o)
      else $error("memory strobe held");
   chk_reboot_busy: assert property
      (reboot_o |=> !reboot_o ##[0:8] boot_busy_o) else $error("no boot");
   chk_fault_pulse: assert property (fault_store_o |=> !fault_store_o)
      else $error("fault pulse held");
   chk_busy_nv: assert property (nv_busy_i |=> boot_busy_o)
      else $error("busy not shown");
   // Boot copy moves nonvolatile data into the default page
   chk_boot_src: assert property
      (mem_en_o && !mem_we_o && boot_busy_o |-> mem_page_o == PAGE_EE)
      else $error("boot read off page");
   chk_boot_dst: assert property
      (mem_en_o && mem_we_o && boot_busy_o |-> mem_page_o == PAGE_DEF &&
       mem_addr_o >= BOOT_FIRST && mem_addr_o <= BOOT_LAST)
      else $error("boot write off range");
   chk_cfg_limit: assert property
      (mem_en_o && mem_we_o && mem_page_o == PAGE_DEF |->
       mem_addr_o <= CFG_LAST) else $error("write past config");
   chk_reset_quiet: assert property (disable iff (1'b0)
      sys_rst_i |=> !mem_en_o && !reboot_o && boot_busy_o)
      else $error("outputs active in reset");
   // Main scenarios seen
   cover property (reboot_o);
   cover property (fault_store_o);
   cover property (mem_en_o && mem_we_o && mem_page_o == PAGE_EE);
endmodule
bind iscp_slave iscp_slave_properties u_props (.clk_sys_i, .sys_rst_i,
   .nv_busy_i, .mem_en_o, .mem_we_o, .mem_page_o, .mem_addr_o, .reboot_o,
   .boot_busy_o, .fault_store_o);
`default_nettype wire

// ### iscp_master_model.sv
// Behavioural two-wire bus master; clock idles high between frames.
// Assumes the bench resolves the data wire from all pull-down enables.
`timescale 1ns/1ps
`default_nettype none
module iscp_master_model (
   // Bus pins
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   // Quarter bit period in ns
   localparam int Q = 640;
   initial scl_o = 1'b1;
   initial sda_low_o = 1'b0;
   // Start or repeated start, data falls while clock high
   task automatic start;
      sda_low_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   // Stop, data rises while clock high
   task automatic stop;
      sda_low_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b0;
      #Q;
   endtask
   // One bit: data set in clock low, sampled mid high
   task automatic bit_io(input logic b, output logic r);
      sda_low_o = !b;
      #Q scl_o = 1'b1;
      #Q r = sda_i;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   // Byte out MSB first, returns slave acknowledge
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // Byte in MSB first, then master acknowledge or refusal
   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!mack, r);
   endtask
endmodule
`default_nettype wire

// ### iscp_slave_tb.sv
// Self-checking bench of the slave engine with memory and master models.
// Assumes the checker and the master model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module iscp_slave_tb
   import iscp_pkg::*;
;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst, nv, scl, m_low, sda_oe, sda_out, en, we, reboot, bbusy;
   logic fstore, a, x1;
   logic [1:0] strap, page;
   logic [7:0] addr, wdata, rdata, d;
   logic [7:0] mem [0:3][0:255];
   logic [7:0] ref_m [0:3][0:255];
   int err_count, samples_checked, seed, fcnt, p, i, n;
   wire logic sda = !(sda_oe || m_low);
   initial forever #20 clk = ~clk;
   initial #7 forever #32 lclk = ~lclk;
   iscp_master_model m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
   iscp_slave uut (.clk_sys_i(clk), .sys_rst_i(rst), .clk_link_i(lclk),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
      .addr_strap_input_i(strap), .mem_en_o(en), .mem_we_o(we),
      .mem_page_o(page), .mem_addr_o(addr), .mem_wdata_o(wdata),
      .mem_rdata_i(rdata), .nv_busy_i(nv), .reboot_o(reboot),
      .boot_busy_o(bbusy), .fault_store_o(fstore));
   // Memory answering the cycle after a read strobe; fault pulse count
   always @(posedge clk)
   begin
      if (en && we)
         mem[page][addr] <= wdata;
      if (en && !we)
         rdata <= mem[page][addr];
      if (fstore === 1'b1)
         fcnt <= fcnt + 1;
   end
   task automatic final_report;
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e)
      begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   function automatic logic [7:0] sa(input logic rw);
      sa = {SLV_ADDR_HI, strap, x1, rw};
   endfunction
   task automatic xw(input logic [7:0] b, input logic e);
      m.wbyte(b, a);
      chk({7'h0, a}, {7'h0, e});
   endtask
   task automatic sb(input logic [7:0] c, input logic e);
      m.start();
      xw(sa(1'b0), 1'b1);
      xw(c, e);
      m.stop();
   endtask
   task automatic rb(input logic [7:0] ad, input logic [7:0] ex);
      sb(ad, 1'b1);
      m.start();
      xw(sa(1'b1), 1'b1);
      m.rbyte(1'b0, d);
      m.stop();
      chk(d, ex);
   endtask
   // Bounded wait for boot copy, then mirror it in the reference
   task automatic wait_boot;
      repeat (20) @(posedge clk);
      for (n = 0; n < 3000 && bbusy !== 1'b0; n++)
         @(posedge clk);
      chk({7'h0, bbusy}, 8'h00);
      if (bbusy !== 1'b0)
         final_report();
      for (i = BOOT_FIRST; i <= BOOT_LAST; i++)
         ref_m[0][i] = ref_m[2][i];
   endtask
   initial
   begin
      err_count = 0;
      samples_checked = 0;
      fcnt = 0;
      seed = 48;
      for (i = 0; i < 1024; i++)
         mem[i / 256][i % 256] = $random(seed);
      ref_m = mem;
      strap = $random(seed);
      x1 = $random(seed);
      rst = 1'b1;
      nv = 1'b0;
      rdata = 8'h00;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      wait_boot();
      rb(8'h20, ref_m[0][32]);
      d = $random(seed);
      m.start();
      xw(sa(1'b0), 1'b1);
      xw(8'h30, 1'b1);
      xw(d, 1'b1);
      m.stop();
      ref_m[0][48] = d;
      sb(8'h30, 1'b1);
      sb(8'h80, 1'b0);
      for (n = 0; n < 2; n++)
      begin
         m.start();
         xw(sa(1'b1), 1'b1);
         m.rbyte(1'b0, d);
         m.stop();
         chk(d, ref_m[0][48 + n]);
      end
      m.start();
      xw({SLV_ADDR_HI, ~strap, 2'h0}, 1'b0);
      m.stop();
      @(posedge clk) #1 nv = 1'b1;
      sb(CMD_BLK_WR, 1'b0);
      @(posedge clk) #1 nv = 1'b0;
      sb(CMD_BLK_RD, 1'b1);
      sb(CMD_EE_ON, 1'b1);
      sb(8'hfe, 1'b1);
      m.start();
      xw(sa(1'b0), 1'b1);
      xw(CMD_BLK_WR, 1'b1);
      xw(8'h00, 1'b0);
      m.start();
      xw(sa(1'b0), 1'b1);
      xw(CMD_BLK_WR, 1'b1);
      xw(8'h03, 1'b1);
      for (p = 254; n < 5; n++)
      begin
         d = $random(seed);
         xw(d, 1'b1);
         ref_m[2][p] = d;
         p = (p < 255) ? p + 1 : 255;
      end
      m.stop();
      chk(mem[2][254], ref_m[2][254]);
      chk(mem[2][255], ref_m[2][255]);
      rb(8'hfe, ref_m[2][254]);
      rb(8'hfe, ref_m[2][254]);
      sb(CMD_EE_OFF, 1'b1);
      rb(8'h05, ref_m[0][5]);
      sb(CMD_EXT_ON, 1'b1);
      sb(8'hfd, 1'b1);
      m.start();
      xw(sa(1'b0), 1'b1);
      xw(CMD_BLK_RD, 1'b1);
      m.start();
      xw(sa(1'b1), 1'b1);
      m.rbyte(1'b1, d);
      chk(d, BLK_RD_COUNT);
      for (n = 0; n < 4; n++)
      begin
         m.rbyte(n < 3, d);
         chk(d, ref_m[1][(n < 2) ? 253 + n : 255]);
      end
      m.stop();
      sb(CMD_EXT_OFF, 1'b1);
      rb(8'h06, ref_m[0][6]);
      sb(CMD_FAULT, 1'b1);
      repeat (20) @(posedge clk);
      chk(fcnt[7:0], 8'h01);
      sb(CMD_EE_ON, 1'b1);
      m.start();
      xw(sa(1'b0), 1'b1);
      xw(CMD_REBOOT, 1'b1);
      xw(8'h00, 1'b0);
      m.stop();
      wait_boot();
      rb(8'h05, ref_m[0][5]);
      rb(8'h30, ref_m[0][48]);
      final_report();
   end
endmodule
`default_nettype wire
